// ### level_persist.sv
// Purpose: reports a line level that has held for a number of cycles
// Assumes: match_i is already synchronous to clk_i
// Notes: any break in the level, or dropping enable, restarts the count

`timescale 1ns/10ps

module level_persist
	import port_disable_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic match_i,
	output logic held_o
);

	localparam logic [PERSIST_W-1:0] LAST = PERSIST_W'(IDLE_PERSIST_CYC - 1);

	logic [PERSIST_W-1:0] count;
	wire counting = enable_i & match_i;
	wire reached = (count >= LAST);

	always_ff @(posedge clk_i) begin
		if (rst_i || !counting) begin
			count <= 10'h000;
			held_o <= 1'b0;
		end else begin
			if (!reached) begin
				count <= count + 10'h001;
			end
			held_o <= reached;
		end
	end

endmodule

// ### port_disable_pkg.sv
// Purpose: shared constants for the host port attach and disable sequencer
// Assumes: 125 MHz system clock, 32-bit classic Wishbone register access
// Notes: all waits are derived from their times in ns and the clock rate

package port_disable_pkg;

	////////////////////////////////////////////////////////////////////////
	// clock and times
	localparam longint CLK_HZ = 125_000_000;
	localparam longint NS_PER_S = 1_000_000_000;
	localparam longint T_POWER_SETTLE_NS = 100_000_000;
	localparam longint T_IDLE_PERSIST_NS = 2_500;
	localparam longint T_ATTACH_DEBOUNCE_NS = 100_000_000;
	localparam longint T_SUSPEND_WAIT_NS = 4_000_000;
	// each wait must exceed its time, so one cycle is added to the floor
	localparam int POWER_SETTLE_CYC = int'(T_POWER_SETTLE_NS * CLK_HZ / NS_PER_S + 1);
	localparam int IDLE_PERSIST_CYC = int'(T_IDLE_PERSIST_NS * CLK_HZ / NS_PER_S + 1);
	localparam int ATTACH_DEBOUNCE_CYC = int'(T_ATTACH_DEBOUNCE_NS * CLK_HZ / NS_PER_S + 1);
	localparam int SUSPEND_WAIT_CYC = int'(T_SUSPEND_WAIT_NS * CLK_HZ / NS_PER_S + 1);
	localparam int TIMER_W = 24;
	localparam int PERSIST_W = 10;

	////////////////////////////////////////////////////////////////////////
	// register map (byte offsets)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_INT_STAT = 8'h08;
	localparam logic [7:0] REG_INT_MASK = 8'h0c;

	// control: state_change_command field
	localparam int CMD_LSB = 0;
	localparam logic [2:0] GO_WAIT_ATTACH_CODE = 3'h1;
	localparam logic [2:0] GO_DISABLED_CODE = 3'h2;

	// status field positions
	localparam int ST_HOST_LSB = 0;
	localparam int ST_SPEED_LSB = 4;
	localparam int ST_XCVR_LSB = 8;
	localparam int ST_TERM_BIT = 10;
	localparam int ST_OPMODE_LSB = 12;
	localparam int ST_CONN_EN_BIT = 16;
	localparam int ST_DISC_EN_BIT = 17;
	localparam int ST_BUSY_BIT = 18;

	// interrupt status and mask layout
	localparam int INT_W = 2;
	localparam int INT_CONNECT_BIT = 0;
	localparam int INT_DISABLED_BIT = 1;
	localparam logic [1:0] INT_MASK_RESET = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// encodings
	localparam logic [2:0] HOST_IDLE = 3'h0;
	localparam logic [2:0] HOST_WAIT_CONNECT = 3'h1;
	localparam logic [2:0] HOST_DISABLED = 3'h2;
	localparam logic [1:0] XCVR_HS = 2'h0;
	localparam logic [1:0] XCVR_FS = 2'h1;
	localparam logic [1:0] XCVR_LS = 2'h2;
	localparam logic TERM_HS = 1'b0;
	localparam logic TERM_FS = 1'b1;
	localparam logic [1:0] OPMODE_NORMAL = 2'h0;
	localparam logic [1:0] OPMODE_NON_DRIVING = 2'h1;
	localparam logic [1:0] OPMODE_POWER_DOWN = 2'h3;
	localparam logic [1:0] SPEED_HS = 2'h0;
	localparam logic [1:0] SPEED_FS = 2'h1;
	localparam logic [1:0] SPEED_LS = 2'h2;
	localparam logic [1:0] LINE_SE0 = 2'h0;
	localparam logic [1:0] LINE_J = 2'h1;
	localparam logic [1:0] LINE_K = 2'h2;

	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_POWER_SETTLE = 8'h02,
		ST_WAIT_LINE = 8'h04,
		ST_DEBOUNCE = 8'h08,
		ST_ATTACHED = 8'h10,
		ST_DRAIN = 8'h20,
		ST_SPEED_DOWN = 8'h40,
		ST_SUSPEND_WAIT = 8'h80
	} seq_state_t;

endpackage

// ### port_disable_sequencer.sv
// Purpose: host port attach debounce and go-disabled transition sequencer
// Assumes: line state, disconnect and busy inputs are synchronous to clk_i
// Notes: registers reached over classic Wishbone, one aligned word each
// a new command wins over any sequence event in the same cycle
// the low-speed disable case takes the full-speed path, power-down only
//
// The address map and the Wishbone slave port were chosen for this implementation.

`timescale 1ns/10ps

module port_disable_sequencer
	import port_disable_pkg::*;
#(
	parameter int POWER_SETTLE_CYC_P = POWER_SETTLE_CYC,
	parameter int ATTACH_DEBOUNCE_CYC_P = ATTACH_DEBOUNCE_CYC,
	parameter int SUSPEND_WAIT_CYC_P = SUSPEND_WAIT_CYC
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] line_state_i,
	input wire logic disconnect_i,
	input wire logic transaction_busy_i,
	output logic [1:0] xcvr_select_o,
	output logic term_select_o,
	output logic [1:0] op_mode_o,
	output logic [1:0] port_speed_select_o,
	output logic connect_detect_en_o,
	output logic disconnect_detect_en_o,
	output logic [2:0] host_state_monitor_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] off);
		addr_is = (adr[7:2] == off[7:2]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	seq_state_t state;
	seq_state_t next_state;
	logic [INT_W-1:0] int_stat;
	logic [INT_W-1:0] int_mask;
	logic [INT_W-1:0] next_int_stat;
	logic timer_done;
	logic idle_held;

	////////////////////////////////////////////////////////////////////////
	// wishbone decode

	wire bus_req = wb_cyc_i & wb_stb_i;
	// writes land on the edge where the master sees ack high
	wire wr_fire = bus_req & wb_we_i & wb_ack_o;
	wire ctrl_wr = wr_fire & addr_is(wb_adr_i, REG_CTRL) & wb_sel_i[0];
	wire stat_wr = wr_fire & addr_is(wb_adr_i, REG_INT_STAT) & wb_sel_i[0];
	wire mask_wr = wr_fire & addr_is(wb_adr_i, REG_INT_MASK) & wb_sel_i[0];
	// codes other than the two below are dropped without effect
	wire [2:0] cmd_code = wb_dat_i[CMD_LSB +: 3];
	wire go_disabled = ctrl_wr & (cmd_code == GO_DISABLED_CODE);
	wire go_attach = ctrl_wr & (cmd_code == GO_WAIT_ATTACH_CODE);
	wire any_cmd = go_disabled | go_attach;

	////////////////////////////////////////////////////////////////////////
	// sequence events

	wire in_wait_line = (state == ST_WAIT_LINE);
	wire in_debounce = (state == ST_DEBOUNCE);
	wire line_idle = (line_state_i == LINE_K) | (line_state_i == LINE_J);
	wire attach_seen = in_wait_line & idle_held & ~any_cmd;
	wire attach_is_ls = (line_state_i == LINE_K);
	// the detector only counts while it is enabled
	wire disc_hit = in_debounce & disconnect_i & disconnect_detect_en_o & ~any_cmd;
	wire settle_done = (state == ST_POWER_SETTLE) & timer_done & ~any_cmd;
	wire debounce_done = in_debounce & timer_done & ~disconnect_i & ~any_cmd;
	wire in_drain = (state == ST_DRAIN);
	wire in_speed_down = (state == ST_SPEED_DOWN);
	wire in_suspend = (state == ST_SUSPEND_WAIT);
	wire drained = in_drain & ~transaction_busy_i & ~any_cmd;
	// high speed is only chosen by the reset handshake outside this block;
	// the drain path still honours it so that path needs no rework later
	wire dev_is_hs = (port_speed_select_o == SPEED_HS);
	wire speed_down = drained & dev_is_hs;
	wire enter_pd = (drained & ~dev_is_hs) | (in_speed_down & ~any_cmd);
	wire suspend_done = in_suspend & timer_done & ~any_cmd;
	wire seq_busy = (state != ST_IDLE) & (state != ST_ATTACHED);

	// a single timer serves the settle, debounce and suspend waits; each start reloads it
	wire timer_start = go_attach | attach_seen | enter_pd;
	wire [TIMER_W-1:0] timer_load = go_attach ? TIMER_W'(POWER_SETTLE_CYC_P) :
		attach_seen ? TIMER_W'(ATTACH_DEBOUNCE_CYC_P) :
		TIMER_W'(SUSPEND_WAIT_CYC_P);

	////////////////////////////////////////////////////////////////////////
	// wait counters

	wait_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(timer_start),
		.load_i(timer_load),
		.done_o(timer_done)
	);

	// the persist counter only runs while the line wait is active
	level_persist u_persist (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(in_wait_line),
		.match_i(line_idle),
		.held_o(idle_held)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer state

	always_comb begin
		next_state = state;
		if (go_disabled) begin
			next_state = ST_DRAIN;
		end else if (go_attach) begin
			next_state = ST_POWER_SETTLE;
		end else begin
			case (state)
				ST_IDLE: begin
					next_state = ST_IDLE;
				end
				ST_POWER_SETTLE: begin
					if (settle_done) begin
						next_state = ST_WAIT_LINE;
					end
				end
				ST_WAIT_LINE: begin
					if (attach_seen) begin
						next_state = ST_DEBOUNCE;
					end
				end
				ST_DEBOUNCE: begin
					if (disc_hit) begin
						next_state = ST_WAIT_LINE;
					end else if (debounce_done) begin
						next_state = ST_ATTACHED;
					end
				end
				ST_ATTACHED: begin
					next_state = ST_ATTACHED;
				end
				ST_DRAIN: begin
					if (speed_down) begin
						next_state = ST_SPEED_DOWN;
					end else if (enter_pd) begin
						next_state = ST_SUSPEND_WAIT;
					end
				end
				ST_SPEED_DOWN: begin
					next_state = ST_SUSPEND_WAIT;
				end
				ST_SUSPEND_WAIT: begin
					if (suspend_done) begin
						next_state = ST_IDLE;
					end
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state monitor and detector gates

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			host_state_monitor_o <= HOST_IDLE;
			connect_detect_en_o <= 1'b0;
			disconnect_detect_en_o <= 1'b0;
		end else if (go_disabled) begin
			host_state_monitor_o <= HOST_DISABLED;
			disconnect_detect_en_o <= 1'b0;
		end else if (go_attach) begin
			host_state_monitor_o <= HOST_WAIT_CONNECT;
			connect_detect_en_o <= 1'b0;
			disconnect_detect_en_o <= 1'b0;
		end else begin
			if (settle_done) begin
				connect_detect_en_o <= 1'b1;
			end
			if (attach_seen) begin
				disconnect_detect_en_o <= 1'b1;
			end
			if (disc_hit) begin
				disconnect_detect_en_o <= 1'b0;
			end
			if (debounce_done) begin
				connect_detect_en_o <= 1'b0;
				disconnect_detect_en_o <= 1'b0;
			end
			if (suspend_done) begin
				disconnect_detect_en_o <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transceiver controls

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xcvr_select_o <= XCVR_FS;
			term_select_o <= TERM_FS;
			op_mode_o <= OPMODE_NON_DRIVING;
			port_speed_select_o <= SPEED_FS;
		end else if (go_attach) begin
			xcvr_select_o <= XCVR_FS;
			term_select_o <= TERM_FS;
			op_mode_o <= OPMODE_POWER_DOWN;
			port_speed_select_o <= SPEED_FS;
		end else begin
			if (attach_seen && attach_is_ls) begin
				xcvr_select_o <= XCVR_LS;
				port_speed_select_o <= SPEED_LS;
			end
			if (disc_hit) begin
				xcvr_select_o <= XCVR_FS;
				port_speed_select_o <= SPEED_FS;
			end
			if (speed_down) begin
				xcvr_select_o <= XCVR_FS;
				term_select_o <= TERM_FS;
				port_speed_select_o <= SPEED_FS;
			end
			// power-down lands one cycle after the speed switch for high speed
			if (enter_pd) begin
				op_mode_o <= OPMODE_POWER_DOWN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt status, set wins over a same-cycle clear

	wire [INT_W-1:0] int_set = {suspend_done, debounce_done};
	wire [INT_W-1:0] int_clr = stat_wr ? wb_dat_i[INT_W-1:0] : 2'h0;
	// a mask written at the same edge already gates the new irq level
	wire [INT_W-1:0] next_int_mask = mask_wr ? wb_dat_i[INT_W-1:0] : int_mask;
	wire next_irq = |(next_int_stat & next_int_mask);

	always_comb begin
		next_int_stat = (int_stat & ~int_clr) | int_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_stat <= 2'h0;
			int_mask <= INT_MASK_RESET;
			irq_o <= 1'b0;
		end else begin
			int_stat <= next_int_stat;
			if (mask_wr) begin
				int_mask <= wb_dat_i[INT_W-1:0];
			end
			irq_o <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read and ack

	logic [31:0] status_word;

	always_comb begin
		status_word = 32'h00000000;
		status_word[ST_HOST_LSB +: 3] = host_state_monitor_o;
		status_word[ST_SPEED_LSB +: 2] = port_speed_select_o;
		status_word[ST_XCVR_LSB +: 2] = xcvr_select_o;
		status_word[ST_TERM_BIT] = term_select_o;
		status_word[ST_OPMODE_LSB +: 2] = op_mode_o;
		status_word[ST_CONN_EN_BIT] = connect_detect_en_o;
		status_word[ST_DISC_EN_BIT] = disconnect_detect_en_o;
		status_word[ST_BUSY_BIT] = seq_busy;
	end

	// the command field is write-only and reads back as zero
	wire [31:0] rd_mux = addr_is(wb_adr_i, REG_STATUS) ? status_word :
		addr_is(wb_adr_i, REG_INT_STAT) ? {30'h00000000, int_stat} :
		addr_is(wb_adr_i, REG_INT_MASK) ? {30'h00000000, int_mask} :
		32'h00000000;

	// read data is refreshed every cycle and only counts while ack is high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			// one wait state; ack drops the cycle after it was given
			wb_ack_o <= bus_req & ~wb_ack_o;
			wb_dat_o <= rd_mux;
		end
	end

endmodule

// ### port_disable_sequencer_assertions.sv
// Purpose: port timing checks for the port disable sequencer
// Assumes: bound to every port_disable_sequencer instance
// Notes: helper counters measure waits in clock cycles
`timescale 1ns/10ps
module port_disable_sequencer_assertions
	import port_disable_pkg::*;
#(
	parameter int POWER_SETTLE_CYC_P = 50,
	parameter int ATTACH_DEBOUNCE_CYC_P = 60,
	parameter int SUSPEND_WAIT_CYC_P = 40
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [1:0] line_state_i,
	input wire logic disconnect_i,
	input wire logic transaction_busy_i,
	input wire logic [1:0] xcvr_select_o,
	input wire logic term_select_o,
	input wire logic [1:0] op_mode_o,
	input wire logic [1:0] port_speed_select_o,
	input wire logic connect_detect_en_o,
	input wire logic disconnect_detect_en_o,
	input wire logic [2:0] host_state_monitor_o,
	input wire logic irq_o
);
	wire logic cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
		&& (wb_adr_i[7:2] == REG_CTRL[7:2]) && wb_sel_i[0];
	wire logic wait_cmd = cmd_wr && (wb_dat_i[2:0] == GO_WAIT_ATTACH_CODE);
	wire logic dis_cmd = cmd_wr && (wb_dat_i[2:0] == GO_DISABLED_CODE);
	wire logic in_wait = host_state_monitor_o == HOST_WAIT_CONNECT;
	wire logic in_dis = host_state_monitor_o == HOST_DISABLED;
	wire logic pd_wait = in_dis && (op_mode_o == OPMODE_POWER_DOWN) && !disconnect_detect_en_o;
	int settle_cnt;
	int disc_cnt;
	int line_cnt;
	int pd_cnt;
	// counters only grow within one run, so int never wraps here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_cnt <= 0;
			disc_cnt <= 0;
			line_cnt <= 0;
			pd_cnt <= 0;
		end else begin
			settle_cnt <= wait_cmd ? 0 : settle_cnt + 1;
			disc_cnt <= disconnect_detect_en_o ? disc_cnt + 1 : 0;
			line_cnt <= (line_state_i != LINE_SE0) ? line_cnt + 1 : 0;
			pd_cnt <= (pd_wait && !transaction_busy_i) ? pd_cnt + 1 : 0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_settle; $rose(connect_detect_en_o) |-> settle_cnt >= POWER_SETTLE_CYC_P; endproperty
	a_settle: assert property (p_settle) else $error("connect enable early");
	property p_idle; $rose(disconnect_detect_en_o) && in_wait |-> line_cnt >= IDLE_PERSIST_CYC;
	endproperty
	a_idle: assert property (p_idle) else $error("disconnect enable early");
	property p_ls; $rose(disconnect_detect_en_o) && in_wait && (line_state_i == LINE_K)
		|-> xcvr_select_o == XCVR_LS && port_speed_select_o == SPEED_LS; endproperty
	a_ls: assert property (p_ls) else $error("low speed not selected");
	property p_debounce; $fell(connect_detect_en_o) && in_wait && !$past(cmd_wr)
		|-> !disconnect_detect_en_o && disc_cnt >= ATTACH_DEBOUNCE_CYC_P; endproperty
	a_debounce: assert property (p_debounce) else $error("debounce end wrong");
	property p_unplug; $fell(disconnect_detect_en_o) && in_wait && connect_detect_en_o
		&& !$past(cmd_wr) |-> xcvr_select_o == XCVR_FS && port_speed_select_o == SPEED_FS;
	endproperty
	a_unplug: assert property (p_unplug) else $error("speed not restored");
	property p_accept; dis_cmd |=> in_dis && !disconnect_detect_en_o; endproperty
	a_accept: assert property (p_accept) else $error("disable accept wrong");
	property p_pd_order; $changed(op_mode_o) && op_mode_o == OPMODE_POWER_DOWN && in_dis
		&& $past(in_dis) |-> $stable(xcvr_select_o) && $stable(port_speed_select_o)
		&& $stable(term_select_o) && xcvr_select_o != XCVR_HS; endproperty
	a_pd_order: assert property (p_pd_order) else $error("speeds not set first");
	property p_drain; in_dis && $past(in_dis) && !disconnect_detect_en_o
		&& $fell(transaction_busy_i) |-> ##2 op_mode_o == OPMODE_POWER_DOWN
		&& term_select_o == TERM_FS && port_speed_select_o != SPEED_HS; endproperty
	a_drain: assert property (p_drain) else $error("power-down missing after drain");
	property p_rearm; $rose(disconnect_detect_en_o) && in_dis |-> pd_cnt >= SUSPEND_WAIT_CYC_P;
	endproperty
	a_rearm: assert property (p_rearm) else $error("disconnect rearm early");
endmodule
bind port_disable_sequencer port_disable_sequencer_assertions #(
	.POWER_SETTLE_CYC_P(POWER_SETTLE_CYC_P), .ATTACH_DEBOUNCE_CYC_P(ATTACH_DEBOUNCE_CYC_P),
	.SUSPEND_WAIT_CYC_P(SUSPEND_WAIT_CYC_P)
) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_state_i(line_state_i),
	.disconnect_i(disconnect_i), .transaction_busy_i(transaction_busy_i),
	.xcvr_select_o(xcvr_select_o), .term_select_o(term_select_o), .op_mode_o(op_mode_o),
	.port_speed_select_o(port_speed_select_o), .connect_detect_en_o(connect_detect_en_o),
	.disconnect_detect_en_o(disconnect_detect_en_o),
	.host_state_monitor_o(host_state_monitor_o), .irq_o(irq_o)
);

// ### port_disable_sequencer_tb.sv
// Purpose: register level tests of attach debounce and go-disabled
// Assumes: shortened waits, classic single Wishbone cycles
// Notes: exact cycle figures are left to the bound checker
`timescale 1ns/10ps
module port_disable_sequencer_tb
	import port_disable_pkg::*;
;
	localparam int PS = 50;
	localparam int DEB = 60;
	localparam int SUS = 40;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic plugged = 1'b0;
	logic low_speed = 1'b0;
	logic busy = 1'b0;
	logic [31:0] dat_o;
	logic ack, irq, disc, tbusy, susp, ten, cen, den;
	logic [1:0] line, xcvr, om, spd;
	logic [2:0] hst;
	int error_cnt = 0;
	int n_checks = 0;
	int cnt = 0;
	int t0;
	always @(posedge clk_i) cnt <= cnt + 1;
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	port_disable_sequencer #(.POWER_SETTLE_CYC_P(PS), .ATTACH_DEBOUNCE_CYC_P(DEB),
		.SUSPEND_WAIT_CYC_P(SUS)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .line_state_i(line), .disconnect_i(disc),
		.transaction_busy_i(tbusy), .xcvr_select_o(xcvr), .term_select_o(ten),
		.op_mode_o(om), .port_speed_select_o(spd), .connect_detect_en_o(cen),
		.disconnect_detect_en_o(den), .host_state_monitor_o(hst), .irq_o(irq));
	usb_periph_model #(.SUSP_CYC(SUS * 3 / 4)) periph (.clk_i(clk_i), .rst_i(rst_i),
		.plugged_i(plugged), .low_speed_i(low_speed), .busy_i(busy), .op_mode_i(om),
		.line_state_o(line), .disconnect_o(disc), .transaction_busy_o(tbusy),
		.suspended_o(susp));
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// called just after a rising edge; returns one edge after release
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			error_cnt++;
			stop_test();
		end
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			bus(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rdat[b] !== v && n < 400);
		if (rdat[b] !== v) begin
			error_cnt++;
			stop_test();
		end
	endtask
	function automatic logic [31:0] st(logic [2:0] h, logic [1:0] s, logic [1:0] x,
		logic t, logic [1:0] o, logic c, logic d);
		return (32'(h) << ST_HOST_LSB) | (32'(s) << ST_SPEED_LSB) | (32'(x) << ST_XCVR_LSB)
			| (32'(t) << ST_TERM_BIT) | (32'(o) << ST_OPMODE_LSB)
			| (32'(c) << ST_CONN_EN_BIT) | (32'(d) << ST_DISC_EN_BIT);
	endfunction
	// the busy bit is a design choice, so it is left out of the compare
	task automatic chk_st(input logic [31:0] exp);
		bus(1'b0, REG_STATUS, 32'h0);
		check(rdat & ~(32'h1 << ST_BUSY_BIT), exp);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_st(st(HOST_IDLE, SPEED_FS, XCVR_FS, TERM_FS, OPMODE_NON_DRIVING, 1'b0, 1'b0));
		chk_rd(REG_CTRL, 32'h0);
		chk_rd(REG_INT_STAT, 32'h0);
		chk_rd(REG_INT_MASK, 32'(INT_MASK_RESET));
		bus(1'b1, 8'h10, 32'hffffffff);
		chk_rd(8'h10, 32'h0);
		bus(1'b1, REG_INT_MASK, 32'h3);
		chk_rd(REG_INT_MASK, 32'h3);
		$display("test reset values done");
		t0 = cnt;
		bus(1'b1, REG_CTRL, 32'(GO_WAIT_ATTACH_CODE));
		poll(ST_CONN_EN_BIT, 1'b1);
		check(32'(cnt - t0 > PS), 32'h1);
		plugged <= 1'b1;
		low_speed <= 1'b1;
		t0 = cnt;
		poll(ST_DISC_EN_BIT, 1'b1);
		check(32'(cnt - t0 > IDLE_PERSIST_CYC), 32'h1);
		chk_st(st(HOST_WAIT_CONNECT, SPEED_LS, XCVR_LS, TERM_FS, OPMODE_POWER_DOWN, 1'b1, 1'b1));
		plugged <= 1'b0;
		poll(ST_DISC_EN_BIT, 1'b0);
		chk_st(st(HOST_WAIT_CONNECT, SPEED_FS, XCVR_FS, TERM_FS, OPMODE_POWER_DOWN, 1'b1, 1'b0));
		chk_rd(REG_INT_STAT, 32'h0);
		plugged <= 1'b1;
		low_speed <= 1'b0;
		poll(ST_DISC_EN_BIT, 1'b1);
		t0 = cnt;
		poll(ST_CONN_EN_BIT, 1'b0);
		check(32'(cnt - t0 >= DEB - 4), 32'h1);
		chk_st(st(HOST_WAIT_CONNECT, SPEED_FS, XCVR_FS, TERM_FS, OPMODE_POWER_DOWN, 1'b0, 1'b0));
		chk_rd(REG_INT_STAT, 32'h1);
		check(32'(irq), 32'h1);
		bus(1'b1, REG_INT_STAT, 32'h1);
		chk_rd(REG_INT_STAT, 32'h0);
		check(32'(irq), 32'h0);
		$display("test attach debounce done");
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b1, REG_INT_MASK, 32'h2);
		// go-disabled is only issued once a connection has been detected
		bus(1'b1, REG_CTRL, 32'(GO_WAIT_ATTACH_CODE));
		poll(ST_CONN_EN_BIT, 1'b1);
		poll(ST_CONN_EN_BIT, 1'b0);
		chk_rd(REG_INT_STAT, 32'h1);
		check(32'(irq), 32'h0);
		bus(1'b1, REG_INT_STAT, 32'h1);
		busy <= 1'b1;
		bus(1'b1, REG_CTRL, 32'(GO_DISABLED_CODE));
		chk_st(st(HOST_DISABLED, SPEED_FS, XCVR_FS, TERM_FS, OPMODE_POWER_DOWN, 1'b0, 1'b0));
		// well past the suspend wait: only the drain keeps the detector off
		repeat (50) @(posedge clk_i);
		chk_st(st(HOST_DISABLED, SPEED_FS, XCVR_FS, TERM_FS, OPMODE_POWER_DOWN, 1'b0, 1'b0));
		busy <= 1'b0;
		t0 = cnt;
		poll(ST_OPMODE_LSB + 1, 1'b1);
		chk_st(st(HOST_DISABLED, SPEED_FS, XCVR_FS, TERM_FS, OPMODE_POWER_DOWN, 1'b0, 1'b0));
		poll(ST_DISC_EN_BIT, 1'b1);
		check(32'(cnt - t0 >= SUS - 4), 32'h1);
		check(32'(susp), 32'h1);
		chk_rd(REG_INT_STAT, 32'h2);
		check(32'(irq), 32'h1);
		bus(1'b1, REG_INT_MASK, 32'h0);
		check(32'(irq), 32'h0);
		bus(1'b1, REG_INT_STAT, 32'h1);
		chk_rd(REG_INT_STAT, 32'h2);
		bus(1'b1, REG_INT_STAT, 32'h2);
		chk_rd(REG_INT_STAT, 32'h0);
		$display("test go disabled done");
		stop_test();
	end
endmodule

// ### usb_periph_model.sv
// Purpose: attached peripheral seen from the host port
// Assumes: bus activity is requested by the bench through busy_i
// Notes: suspend time is scaled with the sequencer's suspend wait
`timescale 1ns/10ps
module usb_periph_model
	import port_disable_pkg::*;
#(
	parameter int SUSP_CYC = 30
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic plugged_i,
	input wire logic low_speed_i,
	input wire logic busy_i,
	input wire logic [1:0] op_mode_i,
	output logic [1:0] line_state_o,
	output logic disconnect_o,
	output logic transaction_busy_o,
	output logic suspended_o
);
	int idle_cnt;
	// unplugged lines fall to se0 through the host pull-downs
	assign line_state_o = !plugged_i ? LINE_SE0 : (low_speed_i ? LINE_K : LINE_J);
	assign disconnect_o = !plugged_i;
	assign transaction_busy_o = busy_i && !suspended_o;
	assign suspended_o = idle_cnt >= SUSP_CYC;
	always_ff @(posedge clk_i) begin
		if (rst_i || busy_i || op_mode_i != OPMODE_POWER_DOWN) begin
			idle_cnt <= 0;
		end else if (!suspended_o) begin
			idle_cnt <= idle_cnt + 1;
		end
	end
endmodule

// ### wait_timer.sv
// Purpose: one-shot down counter for the long sequencer waits
// Assumes: a start pulse reloads the counter even while it runs
// Notes: done_o pulses exactly load_i cycles after the start edge

`timescale 1ns/10ps

module wait_timer
	import port_disable_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [TIMER_W-1:0] load_i,
	output logic done_o
);

	logic [TIMER_W-1:0] count;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= 24'h000000;
			done_o <= 1'b0;
		end else if (start_i) begin
			count <= load_i;
			done_o <= 1'b0;
		end else begin
			done_o <= (count == 24'h000001);
			if (count != 24'h000000) begin
				count <= count - 24'h000001;
			end
		end
	end

endmodule
